// [hw/cmf_consts.vh]
// Constants for the message flag summary register block
`ifndef CMF_CONSTS_VH
`define CMF_CONSTS_VH

// ====================================================================
// Sizes
`define CMF_NUM_OBJ       32
`define CMF_OBJ_W         5
`define CMF_HALF          16
`define CMF_ADDR_W        12
`define CMF_DATA_W        32
`define CMF_EVT_W         4
`define CMF_ID_W          16

// ====================================================================
// Register byte offsets
`define CMF_OFF_TXRQ_LO   12'h100
`define CMF_OFF_TXRQ_HI   12'h104
`define CMF_OFF_FRESH_LO  12'h120
`define CMF_OFF_FRESH_HI  12'h124
`define CMF_OFF_IRQP_LO   12'h140
`define CMF_OFF_IRQP_HI   12'h144
`define CMF_OFF_VALID_LO  12'h160
`define CMF_OFF_VALID_HI  12'h164
`define CMF_OFF_EVT_STAT  12'h180
`define CMF_OFF_EVT_MASK  12'h184
`define CMF_OFF_IRQ_IDENT 12'h188

// ====================================================================
// Event status bit positions
`define CMF_EVT_RX_DATA   0
`define CMF_EVT_RX_REMOTE 1
`define CMF_EVT_TX_DONE   2
`define CMF_EVT_DROPPED   3

// ====================================================================
// Reset and fill values
`define CMF_ZERO32        32'h0000_0000
`define CMF_ZERO16        16'h0000
`define CMF_RESV_ZERO     16'h0000
`define CMF_EVT_RESET     4'h0
`define CMF_ID_NONE       16'h0000
`define CMF_ID_STEP       16'h0001

`endif

// [hw/cmf_obj_flags.v]
// Flag storage for one message object
`timescale 1ns/1ns

module cmf_obj_flags
(
  input  wire pclk,
  input  wire presetn,
  input  wire clk_en,
  input  wire cpu_wr,
  input  wire cpu_valid,
  input  wire cpu_fresh,
  input  wire cpu_irq,
  input  wire cpu_txrq,
  input  wire hnd_sel,
  input  wire hnd_rx_data,
  input  wire hnd_rx_remote,
  input  wire hnd_tx_done,
  input  wire hnd_irq_en,
  output reg  object_valid_q,
  output reg  fresh_data_flag_q,
  output reg  object_irq_pending_q,
  output reg  transmit_request_flag_q
);

  reg valid_d;
  reg fresh_d;
  reg irq_d;
  reg txrq_d;

  // ==================================================================
  // Next state: CPU write first, handler events on top, sets win
  always @*
  begin
    valid_d = cpu_wr ? cpu_valid : object_valid_q;
    fresh_d = cpu_wr ? cpu_fresh : fresh_data_flag_q;
    irq_d   = cpu_wr ? cpu_irq   : object_irq_pending_q;
    txrq_d  = cpu_wr ? cpu_txrq  : transmit_request_flag_q;
    if (hnd_sel && hnd_rx_data)
      fresh_d = 1'b1;
    else if (hnd_sel && hnd_tx_done && !(cpu_wr && cpu_fresh))
      fresh_d = 1'b0;
    if (hnd_sel && hnd_rx_remote)
      txrq_d = 1'b1;
    else if (hnd_sel && hnd_tx_done && !(cpu_wr && cpu_txrq))
      txrq_d = 1'b0;
    if (hnd_sel && hnd_irq_en && (hnd_rx_data || hnd_rx_remote || hnd_tx_done))
      irq_d = 1'b1;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      object_valid_q          <= 1'b0;
      fresh_data_flag_q       <= 1'b0;
      object_irq_pending_q    <= 1'b0;
      transmit_request_flag_q <= 1'b0;
    end
    else if (clk_en)
    begin
      object_valid_q          <= valid_d;
      fresh_data_flag_q       <= fresh_d;
      object_irq_pending_q    <= irq_d;
      transmit_request_flag_q <= txrq_d;
    end
  end

endmodule

// [hw/cmf_summary_regs.v]
// Message flag summary registers with APB slave and event interrupt
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`include "cmf_consts.vh"

module cmf_summary_regs
(
  input  wire                    pclk,
  input  wire                    presetn,
  input  wire                    clk_en,
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`CMF_ADDR_W-1:0]  paddr,
  input  wire [`CMF_DATA_W-1:0]  pwdata,
  output wire [`CMF_DATA_W-1:0]  prdata,
  output wire                    pready,
  output wire                    pslverr,
  input  wire                    ifc_wr,
  input  wire [`CMF_OBJ_W-1:0]   ifc_obj,
  input  wire                    ifc_valid,
  input  wire                    ifc_fresh,
  input  wire                    ifc_irq,
  input  wire                    ifc_txrq,
  input  wire [`CMF_OBJ_W-1:0]   hnd_obj,
  input  wire                    hnd_rx_data,
  input  wire                    hnd_rx_remote,
  input  wire                    hnd_tx_done,
  input  wire                    hnd_irq_en,
  output wire [`CMF_NUM_OBJ-1:0] obj_valid,
  output wire [`CMF_ID_W-1:0]    irq_ident,
  output wire                    irq
);

  // ==================================================================
  // Declarations
  wire [`CMF_NUM_OBJ-1:0] valid_v;
  wire [`CMF_NUM_OBJ-1:0] fresh_v;
  wire [`CMF_NUM_OBJ-1:0] irqp_v;
  wire [`CMF_NUM_OBJ-1:0] txrq_v;

  reg  [`CMF_DATA_W-1:0]  prdata_q;
  reg                     err_q;
  reg                     taken_q;
  reg  [`CMF_EVT_W-1:0]   evt_stat_q;
  reg  [`CMF_EVT_W-1:0]   evt_stat_d;
  reg  [`CMF_EVT_W-1:0]   evt_mask_q;
  reg  [`CMF_ID_W-1:0]    irq_ident_q;
  reg  [`CMF_ID_W-1:0]    irq_ident_d;

  reg  [`CMF_DATA_W-1:0]  rd_c;
  reg                     err_c;
  reg  [`CMF_EVT_W-1:0]   evt_raw;

  wire                    take_req;
  wire                    wr_acc;
  wire                    hnd_any;
  wire                    hnd_ok;
  wire                    hnd_drop;

  integer                 k;

  // ==================================================================
  // Message handler event gating
  assign hnd_any  = hnd_rx_data | hnd_rx_remote | hnd_tx_done;
  assign hnd_ok   = hnd_any & valid_v[hnd_obj];
  assign hnd_drop = hnd_any & ~valid_v[hnd_obj];

  // ==================================================================
  // Per-object flag cells
  genvar g;
  generate
    for (g = 0; g < `CMF_NUM_OBJ; g = g + 1)
    begin : obj
      cmf_obj_flags u_flags
      (
        .pclk                    (pclk),
        .presetn                 (presetn),
        .clk_en                  (clk_en),
        .cpu_wr                  (ifc_wr && (ifc_obj == g)),
        .cpu_valid               (ifc_valid),
        .cpu_fresh               (ifc_fresh),
        .cpu_irq                 (ifc_irq),
        .cpu_txrq                (ifc_txrq),
        .hnd_sel                 (hnd_ok && (hnd_obj == g)),
        .hnd_rx_data             (hnd_rx_data),
        .hnd_rx_remote           (hnd_rx_remote),
        .hnd_tx_done             (hnd_tx_done),
        .hnd_irq_en              (hnd_irq_en),
        .object_valid_q          (valid_v[g]),
        .fresh_data_flag_q       (fresh_v[g]),
        .object_irq_pending_q    (irqp_v[g]),
        .transmit_request_flag_q (txrq_v[g])
      );
    end
  endgenerate

  assign obj_valid = valid_v;

  // ==================================================================
  // Interrupt identification: lowest pending object number plus one
  always @*
  begin
    irq_ident_d = `CMF_ID_NONE;
    for (k = `CMF_NUM_OBJ - 1; k >= 0; k = k - 1)
    begin
      if (irqp_v[k])
        irq_ident_d = k[`CMF_ID_W-1:0] + `CMF_ID_STEP;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_ident_q <= `CMF_ID_NONE;
    else if (clk_en)
      irq_ident_q <= irq_ident_d;
  end

  assign irq_ident = irq_ident_q;

  // ==================================================================
  // APB phase decode
  // A request is taken at the first enabled edge that sees psel; pready waits for it
  assign take_req = psel & ~taken_q;
  assign wr_acc   = psel & penable & pwrite & pready;
  assign pready   = clk_en & taken_q;

  // ==================================================================
  // Read decode
  always @*
  begin
    rd_c  = `CMF_ZERO32;
    err_c = 1'b0;
    case (paddr)
      `CMF_OFF_TXRQ_LO:
        rd_c = {`CMF_RESV_ZERO, txrq_v[`CMF_HALF-1:0]};
      `CMF_OFF_TXRQ_HI:
        rd_c = {`CMF_RESV_ZERO, txrq_v[`CMF_NUM_OBJ-1:`CMF_HALF]};
      `CMF_OFF_FRESH_LO:
        rd_c = {`CMF_RESV_ZERO, fresh_v[`CMF_HALF-1:0]};
      `CMF_OFF_FRESH_HI:
        rd_c = {`CMF_RESV_ZERO, fresh_v[`CMF_NUM_OBJ-1:`CMF_HALF]};
      `CMF_OFF_IRQP_LO:
        rd_c = {`CMF_RESV_ZERO, irqp_v[`CMF_HALF-1:0]};
      `CMF_OFF_IRQP_HI:
        rd_c = {`CMF_RESV_ZERO, irqp_v[`CMF_NUM_OBJ-1:`CMF_HALF]};
      `CMF_OFF_VALID_LO:
        rd_c = {`CMF_RESV_ZERO, valid_v[`CMF_HALF-1:0]};
      `CMF_OFF_VALID_HI:
        rd_c = {`CMF_RESV_ZERO, valid_v[`CMF_NUM_OBJ-1:`CMF_HALF]};
      `CMF_OFF_EVT_STAT:
        rd_c = {{(`CMF_DATA_W-`CMF_EVT_W){1'b0}}, evt_stat_q};
      `CMF_OFF_EVT_MASK:
        rd_c = {{(`CMF_DATA_W-`CMF_EVT_W){1'b0}}, evt_mask_q};
      `CMF_OFF_IRQ_IDENT:
        rd_c = {`CMF_ZERO16, irq_ident_q};
      default:
        err_c = 1'b1;
    endcase
  end

  // ==================================================================
  // Read data captured when the request is taken, answered in the next cycle.
  // A setup cycle lost to a low clk_en is taken in the access cycle, one wait state.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      taken_q  <= 1'b0;
      prdata_q <= `CMF_ZERO32;
      err_q    <= 1'b0;
    end
    else if (clk_en)
    begin
      if (psel && penable && taken_q)
        taken_q <= 1'b0;
      else if (take_req)
      begin
        taken_q  <= 1'b1;
        prdata_q <= pwrite ? `CMF_ZERO32 : rd_c;
        err_q    <= err_c;
      end
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = psel & penable & taken_q & err_q;

  // ==================================================================
  // Event status, write one to clear, set wins over clear
  always @*
  begin
    evt_raw                     = `CMF_EVT_RESET;
    evt_raw[`CMF_EVT_RX_DATA]   = hnd_ok & hnd_rx_data;
    evt_raw[`CMF_EVT_RX_REMOTE] = hnd_ok & hnd_rx_remote;
    evt_raw[`CMF_EVT_TX_DONE]   = hnd_ok & hnd_tx_done;
    evt_raw[`CMF_EVT_DROPPED]   = hnd_drop;
    evt_stat_d = evt_stat_q;
    if (wr_acc && (paddr == `CMF_OFF_EVT_STAT))
      evt_stat_d = evt_stat_q & ~pwdata[`CMF_EVT_W-1:0];
    evt_stat_d = evt_stat_d | evt_raw;
  end

  // Summary registers have no APB write path; only the control interface (ifc_wr) and handler events change the flags
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_stat_q <= `CMF_EVT_RESET;
      evt_mask_q <= `CMF_EVT_RESET;
    end
    else if (clk_en)
    begin
      evt_stat_q <= evt_stat_d;
      if (wr_acc && (paddr == `CMF_OFF_EVT_MASK))
        evt_mask_q <= pwdata[`CMF_EVT_W-1:0];
    end
  end

  assign irq = |(evt_stat_q & evt_mask_q);

endmodule

// [verification/cmf_summary_regs_monitor.sv]
// Assertion checker for the message flag summary block
`timescale 1ns/1ns
module cmf_summary_regs_monitor
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ifc_wr,
  input wire logic [4:0]  ifc_obj,
  input wire logic        ifc_valid,
  input wire logic        ifc_fresh,
  input wire logic        ifc_irq,
  input wire logic        ifc_txrq,
  input wire logic [4:0]  hnd_obj,
  input wire logic        hnd_rx_data,
  input wire logic        hnd_rx_remote,
  input wire logic        hnd_tx_done,
  input wire logic        hnd_irq_en,
  input wire logic [31:0] obj_valid,
  input wire logic [15:0] irq_ident,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  valid_hold_a: assert property (clk_en && !ifc_wr |=> $stable(obj_valid))
    else $error("valid flags moved without a control write");
  valid_load_a: assert property (
    clk_en && ifc_wr |=> obj_valid[$past(ifc_obj)] == $past(ifc_valid))
    else $error("valid flag not loaded");
  resv_zero_a: assert property (
    psel && !penable && clk_en && paddr < 12'h180 |=> prdata[31:16] == 16'h0000)
    else $error("reserved bits not zero");
  valid_lo_a: assert property (
    psel && !penable && !pwrite && clk_en && paddr == 12'h160
      |=> prdata == {16'h0000, $past(obj_valid[15:0])})
    else $error("lower valid read wrong");
  valid_hi_a: assert property (
    psel && !penable && !pwrite && clk_en && paddr == 12'h164
      |=> prdata == {16'h0000, $past(obj_valid[31:16])})
    else $error("upper valid read wrong");
  ident_set_a: assert property (
    clk_en && hnd_rx_data && hnd_irq_en && obj_valid[hnd_obj] ##1 clk_en
      |=> (irq_ident != 16'h0000 && irq_ident <= {11'h000, $past(hnd_obj, 2)} + 16'h0001))
    else $error("identification not updated");
  drop_ident_a: assert property (
    clk_en && hnd_rx_data && !obj_valid[hnd_obj] && !ifc_wr && irq_ident == 16'h0000
      && $past(clk_en) && !$past(ifc_wr)
      && !$past(hnd_rx_data || hnd_rx_remote || hnd_tx_done)
      |-> ##2 irq_ident == 16'h0000)
    else $error("invalid object raised a pending flag");
  write_ignore_a: assert property (
    psel && penable && pwrite && clk_en && !ifc_wr && paddr < 12'h180 |=> $stable(obj_valid))
    else $error("summary write changed flags");

  cover property (psel && penable && !pwrite && pready);
  cover property (hnd_tx_done && hnd_irq_en);
  cover property (pslverr);
  cover property (hnd_rx_data && !obj_valid[hnd_obj]);
  cover property (psel && penable && !clk_en);
endmodule

bind cmf_summary_regs cmf_summary_regs_monitor u_mon
(
  .pclk          (pclk),
  .presetn       (presetn),
  .clk_en        (clk_en),
  .psel          (psel),
  .penable       (penable),
  .pwrite        (pwrite),
  .paddr         (paddr),
  .pwdata        (pwdata),
  .prdata        (prdata),
  .pready        (pready),
  .pslverr       (pslverr),
  .ifc_wr        (ifc_wr),
  .ifc_obj       (ifc_obj),
  .ifc_valid     (ifc_valid),
  .ifc_fresh     (ifc_fresh),
  .ifc_irq       (ifc_irq),
  .ifc_txrq      (ifc_txrq),
  .hnd_obj       (hnd_obj),
  .hnd_rx_data   (hnd_rx_data),
  .hnd_rx_remote (hnd_rx_remote),
  .hnd_tx_done   (hnd_tx_done),
  .hnd_irq_en    (hnd_irq_en),
  .obj_valid     (obj_valid),
  .irq_ident     (irq_ident),
  .irq           (irq)
);

// [verification/cmf_summary_regs_bench.sv]
// Self-checking bench for the message flag summary block
`timescale 1ns/1ns
module cmf_summary_regs_bench;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdat;
  logic        ifc_wr, ifc_valid, ifc_fresh, ifc_irq, ifc_txrq;
  logic [4:0]  ifc_obj, hnd_obj;
  logic        hnd_rx_data, hnd_rx_remote, hnd_tx_done, hnd_irq_en;
  wire  [31:0] prdata, obj_valid;
  wire  [15:0] irq_ident;
  wire         pready, pslverr, irq;
  int          bad_count, tests_run;

  cmf_summary_regs dut
  (
    .pclk          (pclk),
    .presetn       (presetn),
    .clk_en        (clk_en),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .ifc_wr        (ifc_wr),
    .ifc_obj       (ifc_obj),
    .ifc_valid     (ifc_valid),
    .ifc_fresh     (ifc_fresh),
    .ifc_irq       (ifc_irq),
    .ifc_txrq      (ifc_txrq),
    .hnd_obj       (hnd_obj),
    .hnd_rx_data   (hnd_rx_data),
    .hnd_rx_remote (hnd_rx_remote),
    .hnd_tx_done   (hnd_tx_done),
    .hnd_irq_en    (hnd_irq_en),
    .obj_valid     (obj_valid),
    .irq_ident     (irq_ident),
    .irq           (irq)
  );

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ====================================================================
  // Drivers
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rdat, e);
  endtask

  task ctl(input logic [4:0] o, input logic [3:0] f);
    @(posedge pclk);
    ifc_wr  <= 1'b1;
    ifc_obj <= o;
    {ifc_valid, ifc_fresh, ifc_irq, ifc_txrq} <= f;
    @(posedge pclk);
    ifc_wr  <= 1'b0;
  endtask

  task hnd(input logic [2:0] k, input logic [4:0] o, input logic ie);
    @(posedge pclk);
    hnd_obj    <= o;
    hnd_irq_en <= ie;
    {hnd_rx_data, hnd_rx_remote, hnd_tx_done} <= k;
    @(posedge pclk);
    {hnd_rx_data, hnd_rx_remote, hnd_tx_done} <= 3'h0;
  endtask

  // ====================================================================
  // Scenarios
  task t_reset;
    logic [11:0] offs [8];
    offs = '{12'h100, 12'h104, 12'h120, 12'h124, 12'h140, 12'h144, 12'h160, 12'h164};
    foreach (offs[i]) rchk("reset", offs[i], 32'h0000_0000);
  endtask

  task t_drop;
    hnd(3'h4, 5'h05, 1'b1);
    rchk("drop fresh", 12'h120, 32'h0000_0000);
    chk("drop ident", {16'h0000, irq_ident}, 32'h0000_0000);
  endtask

  task t_valid;
    ctl(5'h00, 4'h8);
    ctl(5'h14, 4'h8);
    rchk("valid lo", 12'h160, 32'h0000_0001);
    rchk("valid hi", 12'h164, 32'h0000_0010);
    chk("valid port", obj_valid, 32'h0010_0001);
  endtask

  task t_events;
    hnd(3'h4, 5'h00, 1'b1);
    rchk("fresh lo", 12'h120, 32'h0000_0001);
    rchk("pend lo", 12'h140, 32'h0000_0001);
    hnd(3'h2, 5'h14, 1'b0);
    rchk("txrq hi", 12'h104, 32'h0000_0010);
    rchk("pend hi", 12'h144, 32'h0000_0000);
    hnd(3'h1, 5'h14, 1'b1);
    rchk("txrq done", 12'h104, 32'h0000_0000);
    rchk("pend done", 12'h144, 32'h0000_0010);
    rchk("fresh hi", 12'h124, 32'h0000_0000);
    chk("ident", {16'h0000, irq_ident}, 32'h0000_0001);
    chk("valid kept", obj_valid, 32'h0010_0001);
  endtask

  task t_clear;
    apb(1'b1, 12'h120, 32'hffff_ffff);
    rchk("wr ignored", 12'h120, 32'h0000_0001);
    ctl(5'h00, 4'h8);
    rchk("fresh clr", 12'h120, 32'h0000_0000);
    rchk("pend clr", 12'h140, 32'h0000_0000);
    chk("ident next", {16'h0000, irq_ident}, 32'h0000_0015);
  endtask

  // A handler event while clk_en is low must leave every flag alone, and a
  // read whose setup cycle is frozen must still return live data
  task t_freeze;
    @(posedge pclk);
    clk_en <= 1'b0;
    hnd(3'h4, 5'h14, 1'b1);
    fork
      rchk("frozen fresh", 12'h124, 32'h0000_0000);
      begin
        repeat (3) @(posedge pclk);
        chk("pready frozen", {31'h0000_0000, pready}, 32'h0000_0000);
        clk_en <= 1'b1;
      end
    join
    rchk("frozen status", 12'h180, 32'h0000_000e);
    chk("frozen irq", {31'h0000_0000, irq}, 32'h0000_0000);
    chk("frozen ident", {16'h0000, irq_ident}, 32'h0000_0015);
  endtask

  task t_irq;
    rchk("status", 12'h180, 32'h0000_000f);
    chk("irq masked", {31'h0000_0000, irq}, 32'h0000_0000);
    apb(1'b1, 12'h184, 32'h0000_0001);
    @(posedge pclk);
    chk("irq on", {31'h0000_0000, irq}, 32'h0000_0001);
    apb(1'b1, 12'h180, 32'h0000_0001);
    @(posedge pclk);
    chk("irq off", {31'h0000_0000, irq}, 32'h0000_0000);
    rchk("status left", 12'h180, 32'h0000_000e);
    apb(1'b0, 12'h200, 32'h0000_0000);
    chk("bad err", {31'h0000_0000, rerr}, 32'h0000_0001);
    chk("bad data", rdat, 32'h0000_0000);
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    conclude;
  end

  initial
  begin
    presetn = 1'b0;
    clk_en  = 1'b1;
    {psel, penable, pwrite, ifc_wr, ifc_valid, ifc_fresh, ifc_irq, ifc_txrq} = 8'h00;
    {hnd_rx_data, hnd_rx_remote, hnd_tx_done, hnd_irq_en} = 4'h0;
    {paddr, pwdata, ifc_obj, hnd_obj} = 54'h0;
    bad_count = 0;
    tests_run = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_drop;
    t_valid;
    t_events;
    t_clear;
    t_irq;
    t_freeze;
    conclude;
  end
endmodule
